/* include/pmtr_defs.vh */
// constants shared by the program memory table read block
`ifndef PMTR_DEFS_VH
`define PMTR_DEFS_VH

// program memory geometry
`define PMTR_AW              11
`define PMTR_DW              16
`define PMTR_DEPTH           2048

// fixed vectors
`define PMTR_RESET_VEC       11'h000
`define PMTR_VEC_BASE        11'h004
`define PMTR_IRQ_LAST        4'hc

// interrupt source numbers, in vector order
`define PMTR_IRQ_OCP0        4'h0
`define PMTR_IRQ_OCP1        4'h1
`define PMTR_IRQ_OVP         4'h2
`define PMTR_IRQ_UVP         4'h3
`define PMTR_IRQ_EXT0        4'h4
`define PMTR_IRQ_EXT1        4'h5
`define PMTR_IRQ_MF0         4'h6
`define PMTR_IRQ_MF1         4'h7
`define PMTR_IRQ_MF2         4'h8
`define PMTR_IRQ_LVD         4'h9
`define PMTR_IRQ_TB0         4'ha
`define PMTR_IRQ_TB1         4'hb
`define PMTR_IRQ_ADC         4'hc

// table read
`define PMTR_LAST_PAGE       3'h7
`define PMTR_HI_MASK         8'hff
`define PMTR_CLK_PER_INSTR   4
`define PMTR_TAB_INSTR       2
`define PMTR_TAB_CLKS        (`PMTR_CLK_PER_INSTR * `PMTR_TAB_INSTR)

// register indices on the plain register port
`define PMTR_REG_TPL         4'h0
`define PMTR_REG_TPH         4'h1
`define PMTR_REG_TBH         4'h2
`define PMTR_REG_CTRL        4'h3
`define PMTR_REG_STAT        4'h4
`define PMTR_CTRL_PROG       0
`define PMTR_CTRL_DEBUG      1
`define PMTR_STAT_BUSY       0
`define PMTR_STAT_FRAME      1

// serial frame: op, target, 11 address bits, 16 data bits
`define PMTR_SER_HDR_LAST    5'h0c
`define PMTR_SER_FRM_LAST    5'h1c

`endif

/* src/pmtr_flash_array.v */
// 2K x 16 program memory array with fetch port, shared read port and write port
`timescale 1ns/100ps
`include "pmtr_defs.vh"

module pmtr_flash_array (
  input  wire                    i_clk_sys,
  input  wire [`PMTR_AW-1:0]     i_addr_a,
  output reg  [`PMTR_DW-1:0]     o_q_a,
  input  wire [`PMTR_AW-1:0]     i_addr_b,
  output reg  [`PMTR_DW-1:0]     o_q_b,
  input  wire                    i_wr,
  input  wire [`PMTR_AW-1:0]     i_waddr,
  input  wire [`PMTR_DW-1:0]     i_wdata
);

  reg [`PMTR_DW-1:0] mem [0:`PMTR_DEPTH-1];

  // ----------------------------------------------------------------
  // read ports are registered every cycle; no reset on array data
  // ----------------------------------------------------------------
  always @(posedge i_clk_sys) begin
    o_q_a <= mem[i_addr_a];
    o_q_b <= mem[i_addr_b];
    if (i_wr) begin
      mem[i_waddr] <= i_wdata;
    end
  end

endmodule

/* src/pmtr_serial_port.v */
// serial programming and debug port on one data pin and one input clock pin
`timescale 1ns/100ps
`include "pmtr_defs.vh"

module pmtr_serial_port (
  input  wire                    i_clk_sys,
  input  wire                    i_srst,
  input  wire                    i_enable,
  input  wire                    i_sclk,
  input  wire                    i_sdata,
  output wire                    o_sdata,
  output reg                     o_sdata_oe,
  output reg                     o_req_rd,
  output reg                     o_req_wr,
  output reg                     o_req_ee,
  output reg  [`PMTR_AW-1:0]     o_req_addr,
  output reg  [`PMTR_DW-1:0]     o_req_wdata,
  input  wire [`PMTR_DW-1:0]     i_rdata,
  output wire                    o_frame_active
);

  reg        sclk_s1_r;
  reg        sclk_s2_r;
  reg        sclk_s3_r;
  reg        sd_s1_r;
  reg        sd_s2_r;
  reg [4:0]  bit_cnt_r;
  reg [15:0] shreg_r;
  reg        op_rd_r;
  reg        rd_pend_r;
  reg [15:0] out_r;

  wire        sclk_rise = sclk_s2_r & ~sclk_s3_r;
  wire [15:0] shift_in  = {shreg_r[14:0], sd_s2_r};

  assign o_sdata        = out_r[15];
  assign o_frame_active = (bit_cnt_r != 5'h00);

  // ----------------------------------------------------------------
  // pin synchronisers; edge detect looks only at stages two and three
  // ----------------------------------------------------------------
  always @(posedge i_clk_sys) begin
    sclk_s1_r <= i_sclk;
    sclk_s2_r <= sclk_s1_r;
    sclk_s3_r <= sclk_s2_r;
    sd_s1_r   <= i_sdata;
    sd_s2_r   <= sd_s1_r;
  end

  // ----------------------------------------------------------------
  // frame engine, shared by programming and debug use
  // ----------------------------------------------------------------
  always @(posedge i_clk_sys) begin
    if (i_srst || !i_enable) begin
      bit_cnt_r   <= 5'h00;
      shreg_r     <= 16'h0000;
      op_rd_r     <= 1'b0;
      rd_pend_r   <= 1'b0;
      out_r       <= 16'h0000;
      o_sdata_oe  <= 1'b0;
      o_req_rd    <= 1'b0;
      o_req_wr    <= 1'b0;
      o_req_ee    <= 1'b0;
      o_req_addr  <= 11'h000;
      o_req_wdata <= 16'h0000;
    end else begin
      o_req_rd  <= 1'b0;
      o_req_wr  <= 1'b0;
      rd_pend_r <= o_req_rd;
      if (rd_pend_r) begin
        out_r      <= i_rdata;
        o_sdata_oe <= 1'b1;
      end
      if (sclk_rise) begin
        shreg_r <= shift_in;
        if (o_sdata_oe) begin
          out_r <= {out_r[14:0], 1'b0};
        end
        if (bit_cnt_r == `PMTR_SER_HDR_LAST) begin
          op_rd_r    <= shift_in[12];
          o_req_ee   <= shift_in[11];
          o_req_addr <= shift_in[10:0];
          o_req_rd   <= shift_in[12];
        end
        if (bit_cnt_r == `PMTR_SER_FRM_LAST) begin
          bit_cnt_r  <= 5'h00;
          o_sdata_oe <= 1'b0;
          if (!op_rd_r) begin
            o_req_wdata <= shift_in;
            o_req_wr    <= 1'b1;
          end
        end else begin
          bit_cnt_r <= bit_cnt_r + 5'h01;
        end
      end
    end
  end

endmodule

/* src/pmtr_table_read.v */
// program memory read path: vectors, instruction fetch, table read unit, serial access
//
// Behaviour
// - 2K x 16 flash holds code, tables, vectors
// - after reset fetch starts at word 000H
// - interrupt vectors four apart from 004H to 034H
// - table address: low pointer 7:0, high 10:8
// - tables reached by pointer, never program counter
// - low table byte written to operand register
// - high byte latched; unbacked bits read zero
// - last-page variant forces address bits 10:8 high
// - high byte latch ignores software writes
// - table instructions take two instruction cycles
// - serial access over one data, one clock pin
// - serial port reads/writes flash and EEPROM
// - debug uses same data pin, input clock
// - shared pin functions disabled while debugging
// - debug pins double as programming pins
//
// The strobed register port and the register offsets were decided locally.
`timescale 1ns/100ps
`include "pmtr_defs.vh"

module pmtr_table_read (
  input  wire                    i_clk_sys,
  input  wire                    i_srst,
  // register port
  input  wire [3:0]              i_reg_addr,
  input  wire [7:0]              i_reg_wdata,
  input  wire                    i_reg_wr,
  input  wire                    i_reg_rd,
  output reg  [7:0]              o_reg_rdata,
  // instruction fetch and vectors
  input  wire [`PMTR_AW-1:0]     i_pc,
  output wire [`PMTR_DW-1:0]     o_instr,
  input  wire                    i_irq_ack,
  input  wire [3:0]              i_irq_src,
  output reg                     o_pc_load,
  output reg  [`PMTR_AW-1:0]     o_pc_load_addr,
  output wire                    o_cpu_hold,
  // table read instructions
  input  wire                    i_tab_rd,
  input  wire                    i_tab_last,
  input  wire [7:0]              i_tab_dest,
  output wire                    o_tab_busy,
  output reg                     o_dm_wr,
  output reg  [7:0]              o_dm_addr,
  output reg  [7:0]              o_dm_data,
  // data EEPROM access for the serial port
  output wire                    o_ee_rd,
  output wire                    o_ee_wr,
  output wire [`PMTR_AW-1:0]     o_ee_addr,
  output wire [7:0]              o_ee_wdata,
  input  wire [7:0]              i_ee_rdata,
  // serial programming / debug pins
  input  wire                    i_serial_clock,
  input  wire                    i_serial_data,
  output wire                    o_serial_data,
  output wire                    o_serial_data_oe,
  output wire                    o_pin_func_disable
);

  // ----------------------------------------------------------------
  // local constants and state codes
  // ----------------------------------------------------------------
  localparam [2:0] ST_IDLE  = 3'b001;
  localparam [2:0] ST_WAIT  = 3'b010;
  localparam [2:0] ST_DONE  = 3'b100;
  localparam [31:0] TAB_WAIT_W = `PMTR_TAB_CLKS - 3;
  localparam [3:0]  TAB_WAIT   = TAB_WAIT_W[3:0];

  // ----------------------------------------------------------------
  // functions
  // ----------------------------------------------------------------
  function [`PMTR_AW-1:0] tab_addr;
    input       last;
    input [7:0] low_ptr;
    input [7:0] high_ptr;
    begin
      if (last) begin
        tab_addr = {`PMTR_LAST_PAGE, low_ptr};
      end else begin
        tab_addr = {high_ptr[2:0], low_ptr};
      end
    end
  endfunction

  function [`PMTR_AW-1:0] vec_addr;
    input [3:0] src;
    begin
      vec_addr = `PMTR_VEC_BASE + {5'h00, src, 2'b00};
    end
  endfunction

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  reg  [7:0]              tpl_r;
  reg  [7:0]              tph_r;
  reg  [7:0]              tbh_r;
  reg                     prog_en_r;
  reg                     debug_en_r;
  reg  [2:0]              state_r;
  reg  [2:0]              state_nxt;
  reg  [3:0]              cnt_r;
  reg  [`PMTR_AW-1:0]     tab_addr_r;
  reg  [7:0]              dest_r;
  reg                     boot_pend_r;
  reg                     ee_sel_r;

  wire [`PMTR_DW-1:0]     q_b;
  wire                    ser_rd;
  wire                    ser_wr;
  wire                    ser_ee;
  wire [`PMTR_AW-1:0]     ser_addr;
  wire [`PMTR_DW-1:0]     ser_wdata;
  wire                    ser_frame;
  wire                    ser_enable;
  wire [`PMTR_AW-1:0]     addr_b;
  wire [`PMTR_DW-1:0]     ser_rdata;
  wire                    tab_start;

  // ----------------------------------------------------------------
  // program memory array
  // ----------------------------------------------------------------
  // the table unit and the serial port share read port b; the cpu is
  // held only in programming mode, so in debug mode a serial read can take the port from a table read
  assign addr_b = ser_rd ? ser_addr : tab_addr_r;

  pmtr_flash_array u_array (
    .i_clk_sys (i_clk_sys),
    .i_addr_a  (i_pc),
    .o_q_a     (o_instr),
    .i_addr_b  (addr_b),
    .o_q_b     (q_b),
    .i_wr      (ser_wr & ~ser_ee),
    .i_waddr   (ser_addr),
    .i_wdata   (ser_wdata)
  );

  // ----------------------------------------------------------------
  // serial programming and debug port
  // ----------------------------------------------------------------
  // one engine serves both uses: the debug pins are the programming pins
  assign ser_enable = prog_en_r | debug_en_r;
  assign ser_rdata  = ee_sel_r ? {8'h00, i_ee_rdata} : q_b;

  pmtr_serial_port u_serial (
    .i_clk_sys      (i_clk_sys),
    .i_srst         (i_srst),
    .i_enable       (ser_enable),
    .i_sclk         (i_serial_clock),
    .i_sdata        (i_serial_data),
    .o_sdata        (o_serial_data),
    .o_sdata_oe     (o_serial_data_oe),
    .o_req_rd       (ser_rd),
    .o_req_wr       (ser_wr),
    .o_req_ee       (ser_ee),
    .o_req_addr     (ser_addr),
    .o_req_wdata    (ser_wdata),
    .i_rdata        (ser_rdata),
    .o_frame_active (ser_frame)
  );

  assign o_ee_rd    = ser_rd & ser_ee;
  assign o_ee_wr    = ser_wr & ser_ee;
  assign o_ee_addr  = ser_addr;
  assign o_ee_wdata = ser_wdata[7:0];

  always @(posedge i_clk_sys) begin
    if (i_srst) begin
      ee_sel_r <= 1'b0;
    end else if (ser_rd) begin
      ee_sel_r <= ser_ee;
    end
  end

  // while debugging the pin-shared port functions must not act
  assign o_pin_func_disable = debug_en_r | prog_en_r;
  assign o_cpu_hold         = prog_en_r;

  // ----------------------------------------------------------------
  // reset and interrupt vector loading
  // ----------------------------------------------------------------
  // reset wins over a same-cycle interrupt acknowledge
  always @(posedge i_clk_sys) begin
    if (i_srst) begin
      boot_pend_r    <= 1'b1;
      o_pc_load      <= 1'b0;
      o_pc_load_addr <= `PMTR_RESET_VEC;
    end else if (boot_pend_r) begin
      boot_pend_r    <= 1'b0;
      o_pc_load      <= 1'b1;
      o_pc_load_addr <= `PMTR_RESET_VEC;
    end else if (i_irq_ack && (i_irq_src <= `PMTR_IRQ_LAST)) begin
      o_pc_load      <= 1'b1;
      o_pc_load_addr <= vec_addr(i_irq_src);
    end else begin
      o_pc_load      <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // table read sequencer
  // ----------------------------------------------------------------
  // a request while busy or while programming is dropped; the core is
  // expected to stall for the whole two instruction cycles anyway
  assign tab_start  = i_tab_rd & (state_r == ST_IDLE) & ~prog_en_r;
  assign o_tab_busy = (state_r != ST_IDLE);

  always @* begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: begin
        if (tab_start) begin
          state_nxt = ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (cnt_r == 4'h0) begin
          state_nxt = ST_DONE;
        end
      end
      ST_DONE: begin
        state_nxt = ST_IDLE;
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  always @(posedge i_clk_sys) begin
    if (i_srst) begin
      state_r    <= ST_IDLE;
      cnt_r      <= 4'h0;
      tab_addr_r <= 11'h000;
      dest_r     <= 8'h00;
      tbh_r      <= 8'h00;
      o_dm_wr    <= 1'b0;
      o_dm_addr  <= 8'h00;
      o_dm_data  <= 8'h00;
    end else begin
      state_r <= state_nxt;
      o_dm_wr <= 1'b0;
      if (tab_start) begin
        tab_addr_r <= tab_addr(i_tab_last, tpl_r, tph_r);
        dest_r     <= i_tab_dest;
        cnt_r      <= TAB_WAIT;
      end else if (state_r == ST_WAIT && cnt_r != 4'h0) begin
        cnt_r <= cnt_r - 4'h1;
      end
      if (state_r == ST_DONE) begin
        o_dm_wr   <= 1'b1;
        o_dm_addr <= dest_r;
        o_dm_data <= q_b[7:0];
        tbh_r     <= q_b[15:8] & `PMTR_HI_MASK;
      end
    end
  end

  // ----------------------------------------------------------------
  // register port
  // ----------------------------------------------------------------
  // pointers change only by software writes, never by a table read
  always @(posedge i_clk_sys) begin
    if (i_srst) begin
      tpl_r      <= 8'h00;
      tph_r      <= 8'h00;
      prog_en_r  <= 1'b0;
      debug_en_r <= 1'b0;
    end else if (i_reg_wr) begin
      case (i_reg_addr)
        `PMTR_REG_TPL: begin
          tpl_r <= i_reg_wdata;
        end
        `PMTR_REG_TPH: begin
          tph_r <= i_reg_wdata;
        end
        `PMTR_REG_CTRL: begin
          prog_en_r  <= i_reg_wdata[`PMTR_CTRL_PROG];
          debug_en_r <= i_reg_wdata[`PMTR_CTRL_DEBUG];
        end
        default: begin
          // the high byte latch and the status are not writable
          tpl_r <= tpl_r;
        end
      endcase
    end
  end

  always @(posedge i_clk_sys) begin
    if (i_srst) begin
      o_reg_rdata <= 8'h00;
    end else if (i_reg_rd) begin
      case (i_reg_addr)
        `PMTR_REG_TPL:  o_reg_rdata <= tpl_r;
        `PMTR_REG_TPH:  o_reg_rdata <= tph_r;
        `PMTR_REG_TBH:  o_reg_rdata <= tbh_r;
        `PMTR_REG_CTRL: o_reg_rdata <= {6'h00, debug_en_r, prog_en_r};
        `PMTR_REG_STAT: o_reg_rdata <= {6'h00, ser_frame, o_tab_busy};
        default:        o_reg_rdata <= 8'h00;
      endcase
    end else begin
      o_reg_rdata <= 8'h00;
    end
  end

endmodule

/* tb/pmtr_table_read_assertions.sv */
// concurrent checks on the ports of the program memory table read block
`timescale 1ns/100ps
`include "pmtr_defs.vh"

module pmtr_table_read_chk (
  input wire                i_clk_sys,
  input wire                i_srst,
  input wire [3:0]          i_reg_addr,
  input wire [7:0]          i_reg_wdata,
  input wire                i_reg_wr,
  input wire                i_reg_rd,
  input wire [7:0]          o_reg_rdata,
  input wire                i_irq_ack,
  input wire [3:0]          i_irq_src,
  input wire                o_pc_load,
  input wire [`PMTR_AW-1:0] o_pc_load_addr,
  input wire                o_cpu_hold,
  input wire                i_tab_rd,
  input wire [7:0]          i_tab_dest,
  input wire                o_tab_busy,
  input wire                o_dm_wr,
  input wire [7:0]          o_dm_addr,
  input wire                o_pin_func_disable
);
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (i_srst);

  // a start that the block must take
  wire tab_go = i_tab_rd && !o_tab_busy && !o_cpu_hold;

  sequence seq_busy_run;
    o_tab_busy [*7];
  endsequence
  sequence seq_tab_done;
    !o_tab_busy && o_dm_wr;
  endsequence

  chk_boot_vector: assert property ($fell(i_srst) |=> o_pc_load && o_pc_load_addr == 11'h000)
    else $error("no boot load at word zero");
  chk_irq_vector: assert property (i_irq_ack && i_irq_src <= 4'hc && !$fell(i_srst) |=>
    o_pc_load && o_pc_load_addr == 11'h004 + {5'h00, $past(i_irq_src), 2'b00})
    else $error("wrong interrupt vector load");
  chk_irq_refuse: assert property (i_irq_ack && i_irq_src > 4'hc && !$fell(i_srst) |=> !o_pc_load)
    else $error("load for unknown source");
  chk_tab_cycles: assert property (tab_go |=> seq_busy_run ##1 seq_tab_done)
    else $error("table read not done in two instruction cycles");
  chk_tab_dest: assert property (tab_go |-> ##8 o_dm_addr == $past(i_tab_dest, 8))
    else $error("low byte sent to wrong register");
  chk_prog_refuse: assert property (i_tab_rd && o_cpu_hold && !o_tab_busy |=> !o_tab_busy)
    else $error("table read started while programming");
  chk_rdata_idle: assert property (!$past(i_reg_rd) |-> o_reg_rdata == 8'h00)
    else $error("read data outside read answer cycle");
  chk_unmapped_rd: assert property (i_reg_rd && i_reg_addr > 4'h4 |=> o_reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  chk_ptr_back: assert property (i_reg_wr && i_reg_addr == 4'h0 ##1 i_reg_rd && i_reg_addr == 4'h0
    |=> o_reg_rdata == $past(i_reg_wdata, 2))
    else $error("low pointer read back wrong");
  chk_pin_disable: assert property (o_cpu_hold |-> o_pin_func_disable)
    else $error("shared pin functions live while programming");
endmodule

bind pmtr_table_read pmtr_table_read_chk i_chk (
  .i_clk_sys(i_clk_sys), .i_srst(i_srst), .i_reg_addr(i_reg_addr),
  .i_reg_wdata(i_reg_wdata), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd),
  .o_reg_rdata(o_reg_rdata), .i_irq_ack(i_irq_ack), .i_irq_src(i_irq_src),
  .o_pc_load(o_pc_load), .o_pc_load_addr(o_pc_load_addr), .o_cpu_hold(o_cpu_hold),
  .i_tab_rd(i_tab_rd), .i_tab_dest(i_tab_dest), .o_tab_busy(o_tab_busy),
  .o_dm_wr(o_dm_wr), .o_dm_addr(o_dm_addr), .o_pin_func_disable(o_pin_func_disable)
);

/* tb/pmtr_prog_model.sv */
// serial programmer model driving the programming clock and data pins
`timescale 1ns/100ps

module pmtr_prog_model (
  input  wire i_clk_sys,
  output reg  o_sclk,
  output reg  o_sdat,
  input  wire i_sdat
);
  // clock stands low between frames; data is left at the inverse of the
  // last bit so a stale level can never pass for a good one
  initial begin
    o_sclk = 1'b0;
    o_sdat = 1'b0;
  end

  // ----------------------------------------
  // any frame: op, target, address, data
  // ----------------------------------------
  // the pin is sampled at each own rising clock edge of the data part;
  // the port only moves its output three system cycles after that edge
  task send_frame(input [28:0] frm, output [15:0] data);
    integer k;
    begin
      for (k = 28; k >= 0; k = k - 1) begin
        @(posedge i_clk_sys);
        o_sdat <= frm[k];
        repeat (4) @(posedge i_clk_sys);
        o_sclk <= 1'b1;
        if (k < 16)
          data[k] = i_sdat;
        repeat (5) @(posedge i_clk_sys);
        o_sclk <= 1'b0;
      end
      repeat (10) @(posedge i_clk_sys);
      o_sdat <= ~frm[0];
    end
  endtask

  task write_flash(input [10:0] addr, input [15:0] data);
    reg [15:0] unused;
    begin
      send_frame({1'b0, 1'b0, addr, data}, unused);
    end
  endtask
endmodule

/* tb/pmtr_table_read_test.sv */
// self-checking bench for the program memory table read block
`timescale 1ns/100ps
`include "pmtr_defs.vh"

module pmtr_table_read_test;
  typedef struct packed {
    logic [7:0] tph;
    logic [7:0] tpl;
    logic       last;
    logic [7:0] dest;
    logic [7:0] lo;
    logic [7:0] hi;
  } pmtr_row_t;

  reg         clk, srst, reg_wr, reg_rd, irq_ack, tab_rd, tab_last;
  reg  [3:0]  reg_addr, irq_src;
  reg  [7:0]  reg_wdata, tab_dest, d, ee_rdata;
  reg  [15:0] w;
  reg  [18:0] ee_wr_seen;
  wire [10:0] ee_addr;
  wire [7:0]  ee_wdata;
  wire        ee_rd, ee_wr;
  reg  [10:0] pc;
  wire [7:0]  reg_rdata, dm_addr, dm_data;
  wire [15:0] instr;
  wire [10:0] pc_load_addr;
  wire        pc_load, cpu_hold, tab_busy, dm_wr, sclk, prog_dat, ser_out, ser_oe, func_dis;
  wire        serial_pin = ser_oe ? ser_out : prog_dat;
  integer     fails, n_compared, cycles, i;
  pmtr_row_t  rows [0:4];
  pmtr_row_t  r;

  pmtr_table_read i_dut (
    .i_clk_sys(clk), .i_srst(srst), .i_reg_addr(reg_addr), .i_reg_wdata(reg_wdata),
    .i_reg_wr(reg_wr), .i_reg_rd(reg_rd), .o_reg_rdata(reg_rdata), .i_pc(pc), .o_instr(instr),
    .i_irq_ack(irq_ack), .i_irq_src(irq_src), .o_pc_load(pc_load), .o_pc_load_addr(pc_load_addr),
    .o_cpu_hold(cpu_hold), .i_tab_rd(tab_rd), .i_tab_last(tab_last), .i_tab_dest(tab_dest),
    .o_tab_busy(tab_busy), .o_dm_wr(dm_wr), .o_dm_addr(dm_addr), .o_dm_data(dm_data),
    .o_ee_rd(ee_rd), .o_ee_wr(ee_wr), .o_ee_addr(ee_addr), .o_ee_wdata(ee_wdata), .i_ee_rdata(ee_rdata),
    .i_serial_clock(sclk), .i_serial_data(serial_pin), .o_serial_data(ser_out),
    .o_serial_data_oe(ser_oe), .o_pin_func_disable(func_dis)
  );

  pmtr_prog_model i_prog (
    .i_clk_sys(clk),
    .o_sclk(sclk),
    .o_sdat(prog_dat),
    .i_sdat(serial_pin)
  );

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task check(input [15:0] seen, input [15:0] expct);
    begin
      n_compared = n_compared + 1;
      if (seen !== expct) begin
        fails = fails + 1;
        $display("Error at %0t ns: seen %h expected %h", $time, seen, expct);
      end
    end
  endtask

  task test_done;
    begin
      $display("compared %0d mismatches %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0)
        $display("[ PASS ]");
      else
        $display("[ FAIL ]");
      $finish;
    end
  endtask

  task reg_write(input [3:0] a, input [7:0] v);
    begin
      reg_addr <= a;
      reg_wdata <= v;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
      #1;
    end
  endtask

  // read data stand only in the cycle after the strobe
  task reg_read(input [3:0] a, output [7:0] v);
    begin
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1;
      v = reg_rdata;
    end
  endtask

  task tab_start(input last, input [7:0] dest);
    begin
      tab_last <= last;
      tab_dest <= dest;
      tab_rd <= 1'b1;
      @(posedge clk);
      tab_rd <= 1'b0;
      #1;
    end
  endtask

  task boot_check;
    begin
      srst <= 1'b0;
      @(posedge clk);
      #1;
      check(pc_load, 1'b1);
      check(pc_load_addr, 11'h000);
    end
  endtask

  // a hung handshake must still reach the verdict
  always @(posedge clk) begin
    cycles = cycles + 1;
    if (cycles == 20000) begin
      fails = fails + 1;
      test_done;
    end
  end

  // eeprom stand-in: answers the cycle after its read strobe, records writes
  always @(posedge clk) begin
    if (ee_rd)
      ee_rdata <= ee_addr[7:0] ^ 8'h5a;
    if (ee_wr)
      ee_wr_seen <= {ee_addr, ee_wdata};
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    {srst, reg_wr, reg_rd, irq_ack, tab_rd, tab_last} = 6'b10_0000;
    {reg_addr, irq_src, reg_wdata, tab_dest, pc} = 35'h0_0000_0000;
    fails = 0;
    n_compared = 0;
    cycles = 0;
    rows[0] = '{8'h07, 8'h06, 1'b0, 8'h21, 8'h5c, 8'h1a};
    rows[1] = '{8'h02, 8'h06, 1'b1, 8'h22, 8'h5c, 8'h1a};
    rows[2] = '{8'hf8, 8'hff, 1'b0, 8'h80, 8'he7, 8'hc3};
    rows[3] = '{8'hfb, 8'ha5, 1'b0, 8'hff, 8'hf0, 8'h00};
    rows[4] = '{8'h00, 8'hff, 1'b1, 8'h00, 8'h01, 8'h80};
    repeat (12) @(posedge clk);
    boot_check;
    for (i = 0; i < 4; i = i + 1) begin
      reg_write(4'h3, i[7:0]);
      check(func_dis, i != 0);
      check(cpu_hold, i[0]);
      reg_read(4'h3, d);
      check(d, i);
    end
    reg_write(4'h3, 8'h01);
    tab_start(1'b0, 8'h33);
    check(tab_busy, 1'b0);
    i_prog.write_flash(11'h706, 16'h1a5c);
    i_prog.write_flash(11'h0ff, 16'hc3e7);
    i_prog.write_flash(11'h3a5, 16'h00f0);
    i_prog.write_flash(11'h7ff, 16'h8001);
    i_prog.send_frame({2'b10, 11'h0ff, 16'h0000}, w);
    check(w, 16'hc3e7);
    i_prog.send_frame({2'b11, 11'h0a5, 16'h0000}, w);
    check(w, 16'h00ff);
    i_prog.send_frame({2'b01, 11'h123, 16'h0077}, w);
    check(ee_wr_seen[18:8], 11'h123);
    check(ee_wr_seen[7:0], 8'h77);
    check(ser_oe, 1'b0);
    reg_write(4'h3, 8'h00);
    pc <= 11'h706;
    @(posedge clk);
    #1;
    check(instr, 16'h1a5c);
    for (i = 0; i < 5; i = i + 1) begin
      r = rows[i];
      reg_write(4'h1, r.tph);
      reg_write(4'h0, r.tpl);
      tab_start(r.last, r.dest);
      check(tab_busy, 1'b1);
      reg_read(4'h4, d);
      check(d, 8'h01);
      repeat (6) @(posedge clk);
      #1;
      check({tab_busy, dm_wr}, 2'b01);
      check(dm_addr, r.dest);
      check(dm_data, r.lo);
      reg_read(4'h2, d);
      check(d, r.hi);
      reg_read(4'h0, d);
      check(d, r.tpl);
      reg_read(4'h1, d);
      check(d, r.tph);
    end
    reg_write(4'h2, 8'h55);
    reg_read(4'h2, d);
    check(d, 8'h80);
    reg_write(4'h0, 8'h3c);
    reg_read(4'h0, d);
    check(d, 8'h3c);
    reg_read(4'h9, d);
    check(d, 8'h00);
    tab_start(1'b0, 8'h11);
    repeat (2) @(posedge clk);
    tab_start(1'b0, 8'h22);
    repeat (4) @(posedge clk);
    #1;
    check(dm_wr, 1'b1);
    check(dm_addr, 8'h11);
    @(posedge clk);
    #1;
    check(tab_busy, 1'b0);
    // acks only come while no table read runs
    for (i = 0; i < 14; i = i + 1) begin
      irq_ack <= 1'b1;
      irq_src <= i[3:0];
      @(posedge clk);
      irq_ack <= 1'b0;
      #1;
      check(pc_load, i < 13);
      if (i < 13)
        check(pc_load_addr, 11'h004 + 4 * i);
    end
    srst <= 1'b1;
    repeat (2) @(posedge clk);
    boot_check;
    test_done;
  end
endmodule
